// ==== verilog/cdm_data_move.sv ====
// Data-move group decoder and executor of the 8-bit core
`default_nettype none
`include "cdm_regs.svh"
module cdm_data_move (
	// Clock, reset, enable
	input  wire logic                i_sys_clk,
	input  wire logic                i_srst,
	input  wire logic                i_ce,
	// Instruction stream
	input  wire logic                i_instr_valid,
	input  wire cdm_pkg::cdm_instr_s i_instr,
	input  wire logic [15:0]         i_pc,
	output logic                     o_instr_ready,
	output logic                     o_done,
	output var cdm_pkg::cdm_info_s   o_info,
	// Program memory read
	output logic                     o_code_rd,
	output logic [15:0]              o_code_addr,
	input  wire logic [7:0]          i_code_rdata,
	// External data memory
	output logic                     o_xmem_rd,
	output logic                     o_xmem_wr,
	output logic [15:0]              o_xmem_addr,
	output logic [7:0]               o_xmem_wdata,
	input  wire logic [7:0]          i_xmem_rdata,
	// Bit operand lookup
	input  wire logic [7:0]          i_bit_addr,
	output logic                     o_bit_value,
	// Core state
	output logic [7:0]               o_acc,
	output logic [7:0]               o_sp,
	output logic [7:0]               o_psw,
	output logic [15:0]              o_data_pointer
);
	// ==========================================================
	// Declarations
	cdm_pkg::cdm_info_s  dec_info;
	cdm_pkg::cdm_info_s  cur_info;
	cdm_pkg::cdm_instr_s hold_reg;
	cdm_pkg::cdm_instr_s cur;
	logic [7:0]  iram [0:255];
	logic [7:0]  acc_reg;
	logic [7:0]  b_reg;
	logic [7:0]  psw_reg;
	logic [7:0]  sp_reg;
	logic [15:0] data_pointer_reg;
	logic        tmr_idle;
	logic        tmr_last;
	logic        accept;
	logic        fin;
	logic [1:0]  bank;
	logic [7:0]  rn_addr;
	logic [7:0]  ri_addr;
	logic [7:0]  rn_val;
	logic [7:0]  ri_ptr;
	logic [7:0]  ri_val;
	logic [7:0]  dir_b1;
	logic [7:0]  stack_top;
	logic [7:0]  ext_data;
	logic        code_d_reg;
	logic        xrd_d_reg;
	logic [7:0]  ext_hold_reg;
	logic        acc_we;
	logic [7:0]  acc_wd;
	logic        wr_en;
	logic        wr_ind;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        wr_iram;
	logic        wr_sfr;
	logic        sp_we;
	logic [7:0]  sp_wd;
	logic        data_pointer_we;
	logic [15:0] data_pointer_wd;
	logic [7:0]  bit_byte;
	logic [2:0]  bit_idx;
	logic [7:0]  bit_byte_val;
	logic        movc_in;
	logic        movx_in;

	// Read of the direct space: low half RAM, high half SFRs
	function automatic logic [7:0] rd_dir(input logic [7:0] a);
		logic [7:0] v;
		v = iram[a];
		if (a[7]) begin
			case (a)
				`CDM_SFR_ACC: v = acc_reg;
				`CDM_SFR_B:   v = b_reg;
				`CDM_SFR_PSW: v = psw_reg;
				`CDM_SFR_SP:  v = sp_reg;
				`CDM_SFR_DPL: v = data_pointer_reg[7:0];
				`CDM_SFR_DPH: v = data_pointer_reg[15:8];
				default:      v = 8'h00;
			endcase
		end
		return v;
	endfunction : rd_dir

	// ==========================================================
	// Opcode decode: class, mode, length, time
	always_comb begin
		dec_info = '{cdm_pkg::OP_NONE, cdm_pkg::MD_NONE, 2'h1, 3'h1};
		casez (i_instr.opcode)
			8'b1110_1???: dec_info = '{cdm_pkg::OP_MOV_A_R, cdm_pkg::MD_REG, 2'h1, 3'h1};
			8'hE5: dec_info = '{cdm_pkg::OP_MOV_A_D, cdm_pkg::MD_DIR, 2'h2, 3'h2};
			8'b1110_011?: dec_info = '{cdm_pkg::OP_MOV_A_I, cdm_pkg::MD_IND8, 2'h1, 3'h2};
			8'h74: dec_info = '{cdm_pkg::OP_MOV_A_K, cdm_pkg::MD_IMM, 2'h2, 3'h2};
			8'b1111_1???: dec_info = '{cdm_pkg::OP_MOV_R_A, cdm_pkg::MD_IMPL, 2'h1, 3'h1};
			8'b1010_1???: dec_info = '{cdm_pkg::OP_MOV_R_D, cdm_pkg::MD_DIR, 2'h2, 3'h3};
			8'b0111_1???: dec_info = '{cdm_pkg::OP_MOV_R_K, cdm_pkg::MD_IMM, 2'h2, 3'h2};
			8'hF5: dec_info = '{cdm_pkg::OP_MOV_D_A, cdm_pkg::MD_IMPL, 2'h2, 3'h2};
			8'b1000_1???: dec_info = '{cdm_pkg::OP_MOV_D_R, cdm_pkg::MD_REG, 2'h2, 3'h2};
			8'h85: dec_info = '{cdm_pkg::OP_MOV_D_D, cdm_pkg::MD_DIR, 2'h3, 3'h3};
			8'b1000_011?: dec_info = '{cdm_pkg::OP_MOV_D_I, cdm_pkg::MD_IND8, 2'h2, 3'h3};
			8'h75: dec_info = '{cdm_pkg::OP_MOV_D_K, cdm_pkg::MD_IMM, 2'h3, 3'h3};
			8'b1111_011?: dec_info = '{cdm_pkg::OP_MOV_I_A, cdm_pkg::MD_IMPL, 2'h1, 3'h2};
			8'b1010_011?: dec_info = '{cdm_pkg::OP_MOV_I_D, cdm_pkg::MD_DIR, 2'h2, 3'h3};
			8'b0111_011?: dec_info = '{cdm_pkg::OP_MOV_I_K, cdm_pkg::MD_IMM, 2'h2, 3'h2};
			8'h90: dec_info = '{cdm_pkg::OP_MOV_DP_K, cdm_pkg::MD_IMM, 2'h3, 3'h3};
			8'h93: dec_info = '{cdm_pkg::OP_MOVC_DP, cdm_pkg::MD_INDEX, 2'h1, 3'h5};
			8'h83: dec_info = '{cdm_pkg::OP_MOVC_PC, cdm_pkg::MD_INDEX, 2'h1, 3'h4};
			8'b1110_001?: dec_info = '{cdm_pkg::OP_MOVX_RI, cdm_pkg::MD_IND8, 2'h1, 3'h4};
			8'hE0: dec_info = '{cdm_pkg::OP_MOVX_RDP, cdm_pkg::MD_IND16, 2'h1, 3'h3};
			8'b1111_001?: dec_info = '{cdm_pkg::OP_MOVX_WI, cdm_pkg::MD_IND8, 2'h1, 3'h5};
			8'hF0: dec_info = '{cdm_pkg::OP_MOVX_WDP, cdm_pkg::MD_IND16, 2'h1, 3'h4};
			8'hC0: dec_info = '{cdm_pkg::OP_PUSH, cdm_pkg::MD_DIR, 2'h2, 3'h3};
			8'hD0: dec_info = '{cdm_pkg::OP_POP, cdm_pkg::MD_DIR, 2'h2, 3'h2};
			8'b1100_1???: dec_info = '{cdm_pkg::OP_XCH_R, cdm_pkg::MD_REG, 2'h1, 3'h2};
			8'hC5: dec_info = '{cdm_pkg::OP_XCH_D, cdm_pkg::MD_DIR, 2'h2, 3'h3};
			8'b1100_011?: dec_info = '{cdm_pkg::OP_XCH_I, cdm_pkg::MD_IND8, 2'h1, 3'h3};
			8'b1101_011?: dec_info = '{cdm_pkg::OP_XCHD, cdm_pkg::MD_IND8, 2'h1, 3'h3};
			default: ;
		endcase
	end

	// ==========================================================
	// Instruction timing
	cdm_cycle_timer u_timer (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_ce      (i_ce),
		.i_load    (accept),
		.i_cycles  (dec_info.cycles),
		.o_idle    (tmr_idle),
		.o_last    (tmr_last)
	);

	// Start and end of an instruction
	assign o_instr_ready = tmr_idle;
	assign accept = i_ce & i_instr_valid & tmr_idle;
	assign fin = accept ? (dec_info.cycles == `CDM_CYC_ONE) : (i_ce & tmr_last);
	assign o_done = fin;
	assign cur = accept ? i_instr : hold_reg;
	assign cur_info = accept ? dec_info : o_info;

	// Hold the instruction and its decode
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			hold_reg <= '0;
			o_info <= '{cdm_pkg::OP_NONE, cdm_pkg::MD_NONE, 2'h1, 3'h1};
		end else if (accept) begin
			hold_reg <= i_instr;
			o_info <= dec_info;
		end
	end

	// ==========================================================
	// Operand addressing
	assign bank = psw_reg[`CDM_PSW_BANK_HI:`CDM_PSW_BANK_LO];
	assign rn_addr = {3'h0, bank, cur.opcode[2:0]};
	assign ri_addr = {3'h0, bank, 2'h0, cur.opcode[0]};
	assign rn_val = iram[rn_addr];
	assign ri_ptr = iram[ri_addr];
	assign ri_val = iram[ri_ptr];
	assign dir_b1 = rd_dir(cur.op1);
	assign stack_top = iram[sp_reg];
	assign ext_data = code_d_reg ? i_code_rdata : (xrd_d_reg ? i_xmem_rdata : ext_hold_reg);

	// Write-back decision at the last cycle
	always_comb begin
		acc_we = 1'b0;
		acc_wd = acc_reg;
		wr_en = 1'b0;
		wr_ind = 1'b0;
		wr_addr = cur.op1;
		wr_data = acc_reg;
		sp_we = 1'b0;
		sp_wd = sp_reg;
		data_pointer_we = 1'b0;
		data_pointer_wd = {cur.op1, cur.op2};
		unique case (cur_info.op)
			cdm_pkg::OP_NONE: ;
			cdm_pkg::OP_MOV_A_R: begin
				acc_we = 1'b1;
				acc_wd = rn_val;
			end
			cdm_pkg::OP_MOV_A_D: begin
				acc_we = 1'b1;
				acc_wd = dir_b1;
			end
			cdm_pkg::OP_MOV_A_I: begin
				acc_we = 1'b1;
				acc_wd = ri_val;
			end
			cdm_pkg::OP_MOV_A_K: begin
				acc_we = 1'b1;
				acc_wd = cur.op1;
			end
			cdm_pkg::OP_MOV_R_A: begin
				wr_en = 1'b1;
				wr_ind = 1'b1;
				wr_addr = rn_addr;
			end
			cdm_pkg::OP_MOV_R_D, cdm_pkg::OP_MOV_R_K: begin
				wr_en = 1'b1;
				wr_ind = 1'b1;
				wr_addr = rn_addr;
				wr_data = (cur_info.op == cdm_pkg::OP_MOV_R_D) ? dir_b1 : cur.op1;
			end
			cdm_pkg::OP_MOV_D_A: wr_en = 1'b1;
			cdm_pkg::OP_MOV_D_R: begin
				wr_en = 1'b1;
				wr_data = rn_val;
			end
			cdm_pkg::OP_MOV_D_D: begin
				wr_en = 1'b1;
				wr_addr = cur.op2;
				wr_data = dir_b1;
			end
			cdm_pkg::OP_MOV_D_I: begin
				wr_en = 1'b1;
				wr_data = ri_val;
			end
			cdm_pkg::OP_MOV_D_K: begin
				wr_en = 1'b1;
				wr_data = cur.op2;
			end
			cdm_pkg::OP_MOV_I_A, cdm_pkg::OP_MOV_I_D, cdm_pkg::OP_MOV_I_K: begin
				wr_en = 1'b1;
				wr_ind = 1'b1;
				wr_addr = ri_ptr;
				if (cur_info.op == cdm_pkg::OP_MOV_I_D) begin
					wr_data = dir_b1;
				end else if (cur_info.op == cdm_pkg::OP_MOV_I_K) begin
					wr_data = cur.op1;
				end
			end
			cdm_pkg::OP_MOV_DP_K: data_pointer_we = 1'b1;
			cdm_pkg::OP_MOVC_DP, cdm_pkg::OP_MOVC_PC, cdm_pkg::OP_MOVX_RI,
			cdm_pkg::OP_MOVX_RDP: begin
				acc_we = 1'b1;
				acc_wd = ext_data;
			end
			cdm_pkg::OP_MOVX_WI, cdm_pkg::OP_MOVX_WDP: ;
			cdm_pkg::OP_PUSH: begin
				sp_we = 1'b1;
				sp_wd = sp_reg + 8'h01;
				wr_en = 1'b1;
				wr_ind = 1'b1;
				wr_addr = sp_wd;
				wr_data = dir_b1;
			end
			cdm_pkg::OP_POP: begin
				sp_we = 1'b1;
				sp_wd = sp_reg - 8'h01;
				wr_en = 1'b1;
				wr_data = stack_top;
			end
			cdm_pkg::OP_XCH_R: begin
				acc_we = 1'b1;
				acc_wd = rn_val;
				wr_en = 1'b1;
				wr_ind = 1'b1;
				wr_addr = rn_addr;
			end
			cdm_pkg::OP_XCH_D: begin
				acc_we = 1'b1;
				acc_wd = dir_b1;
				wr_en = 1'b1;
			end
			cdm_pkg::OP_XCH_I: begin
				acc_we = 1'b1;
				acc_wd = ri_val;
				wr_en = 1'b1;
				wr_ind = 1'b1;
				wr_addr = ri_ptr;
			end
			cdm_pkg::OP_XCHD: begin
				acc_we = 1'b1;
				acc_wd = {acc_reg[7:4], ri_val[3:0]};
				wr_en = 1'b1;
				wr_ind = 1'b1;
				wr_addr = ri_ptr;
				wr_data = {ri_val[7:4], acc_reg[3:0]};
			end
			default: ;
		endcase
	end

	// Route the write to RAM or to an SPECIAL_FUNCTION_REGISTER
	assign wr_iram = fin & wr_en & (wr_ind | ~wr_addr[7]);
	assign wr_sfr = fin & wr_en & ~wr_ind & wr_addr[7];

	// ==========================================================
	// Core state
	always_ff @(posedge i_sys_clk) begin
		if (wr_iram) begin
			iram[wr_addr] <= wr_data;
		end
	end

	// Accumulator: explicit load wins over SPECIAL_FUNCTION_REGISTER write
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			acc_reg <= `CDM_BYTE_RST;
		end else if (fin && acc_we) begin
			acc_reg <= acc_wd;
		end else if (wr_sfr && wr_addr == `CDM_SFR_ACC) begin
			acc_reg <= wr_data;
		end
	end

	// B and status word
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			b_reg <= `CDM_BYTE_RST;
			psw_reg <= `CDM_BYTE_RST;
		end else if (wr_sfr) begin
			if (wr_addr == `CDM_SFR_B) begin
				b_reg <= wr_data;
			end
			if (wr_addr == `CDM_SFR_PSW) begin
				psw_reg <= wr_data;
			end
		end
	end

	// Stack pointer: a pop into itself keeps the popped byte
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			sp_reg <= `CDM_SP_RST;
		end else if (wr_sfr && wr_addr == `CDM_SFR_SP) begin
			sp_reg <= wr_data;
		end else if (fin && sp_we) begin
			sp_reg <= sp_wd;
		end
	end

	// Data pointer
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			data_pointer_reg <= `CDM_DATA_POINTER_RST;
		end else if (fin && data_pointer_we) begin
			data_pointer_reg <= data_pointer_wd;
		end else if (wr_sfr && wr_addr == `CDM_SFR_DPL) begin
			data_pointer_reg[7:0] <= wr_data;
		end else if (wr_sfr && wr_addr == `CDM_SFR_DPH) begin
			data_pointer_reg[15:8] <= wr_data;
		end
	end

	// ==========================================================
	// Memory strobes, issued in the cycle after the start
	assign movc_in = (dec_info.op == cdm_pkg::OP_MOVC_DP) | (dec_info.op == cdm_pkg::OP_MOVC_PC);
	assign movx_in = (dec_info.mode == cdm_pkg::MD_IND8) | (dec_info.mode == cdm_pkg::MD_IND16);

	// Program memory read
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_code_rd <= 1'b0;
			o_code_addr <= 16'h0000;
		end else if (i_ce) begin
			o_code_rd <= accept & movc_in;
			if (accept && movc_in) begin
				o_code_addr <= ((dec_info.op == cdm_pkg::OP_MOVC_DP) ? data_pointer_reg : i_pc)
					+ {8'h00, acc_reg};
			end
		end
	end

	// External data memory access
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_xmem_rd <= 1'b0;
			o_xmem_wr <= 1'b0;
			o_xmem_addr <= 16'h0000;
			o_xmem_wdata <= 8'h00;
		end else if (i_ce) begin
			o_xmem_rd <= accept & ((dec_info.op == cdm_pkg::OP_MOVX_RI)
				| (dec_info.op == cdm_pkg::OP_MOVX_RDP));
			o_xmem_wr <= accept & ((dec_info.op == cdm_pkg::OP_MOVX_WI)
				| (dec_info.op == cdm_pkg::OP_MOVX_WDP));
			if (accept && movx_in && (dec_info.op >= cdm_pkg::OP_MOVX_RI)
				&& (dec_info.op <= cdm_pkg::OP_MOVX_WDP)) begin
				o_xmem_addr <= (dec_info.mode == cdm_pkg::MD_IND16) ? data_pointer_reg
					: {`CDM_XPAGE, ri_ptr};
				o_xmem_wdata <= acc_reg;
			end
		end
	end

	// Returned read data, held for the later commit
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			code_d_reg <= 1'b0;
			xrd_d_reg <= 1'b0;
			ext_hold_reg <= 8'h00;
		end else if (i_ce) begin
			code_d_reg <= o_code_rd;
			xrd_d_reg <= o_xmem_rd;
			ext_hold_reg <= ext_data;
		end
	end

	// ==========================================================
	// Bit operand lookup
	cdm_bit_locate u_bit (
		.i_bit_addr  (i_bit_addr),
		.o_byte_addr (bit_byte),
		.o_bit_index (bit_idx)
	);
	assign bit_byte_val = rd_dir(bit_byte);

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_bit_value <= 1'b0;
		end else if (i_ce) begin
			o_bit_value <= bit_byte_val[bit_idx];
		end
	end

	// State outputs
	assign o_acc = acc_reg;
	assign o_sp = sp_reg;
	assign o_psw = psw_reg;
	assign o_data_pointer = data_pointer_reg;

	// ==========================================================
	// Assertions
	a_reg_move_one: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_MOV_A_R |-> o_done ##1 acc_reg == $past(rn_val))
		else $error("register to accumulator not done in one cycle");
	a_dir_load_two: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_MOV_A_D |-> !o_done ##1 o_done
		##1 acc_reg == $past(dir_b1))
		else $error("direct load to accumulator wrong");
	a_imm_load_acc: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_MOV_A_K |-> ##2 acc_reg == $past(i_instr.op1, 2))
		else $error("immediate not loaded into accumulator");
	a_movc_dp_five: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_MOVC_DP |-> ##1 (!o_done)[*3] ##1 o_done)
		else $error("pointer code read not five cycles");
	a_movc_addr: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_MOVC_DP |=> o_code_rd
		&& o_code_addr == $past(data_pointer_reg) + {8'h00, $past(acc_reg)})
		else $error("indexed code address wrong");
	a_xwr_ri_five: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_MOVX_WI |=> o_xmem_wr
		&& o_xmem_addr == {`CDM_XPAGE, $past(ri_ptr)} ##1 (!o_done)[*2] ##1 o_done)
		else $error("8-bit external write wrong");
	a_xrd_dp_three: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_MOVX_RDP |=> o_xmem_rd ##1 o_done
		##1 acc_reg == $past(i_xmem_rdata))
		else $error("16-bit external read wrong");
	a_push_sp_inc: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_PUSH && i_instr.op1 != `CDM_SFR_SP
		|-> ##3 sp_reg == $past(sp_reg, 3) + 8'h01)
		else $error("push did not raise stack pointer");
	a_pop_sp_dec: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_POP && i_instr.op1 != `CDM_SFR_SP
		|-> ##2 sp_reg == $past(sp_reg, 2) - 8'h01)
		else $error("pop did not lower stack pointer");
	a_xchd_high: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.op == cdm_pkg::OP_XCHD |-> ##3 acc_reg[7:4] == $past(acc_reg[7:4], 3))
		else $error("digit exchange touched high nibble");
	a_busy_refuse: assert property (@(posedge i_sys_clk) disable iff (i_srst || !i_ce)
		accept && dec_info.cycles == 3'h3 |=> !o_instr_ready ##1 !o_instr_ready ##1 o_instr_ready)
		else $error("ready not held off for instruction length");
endmodule : cdm_data_move
`default_nettype wire

// ==== include/cdm_regs.svh ====
// Constants for the data-move decoder and executor
//
// What this block does
// - Direct mode: 8-bit field, RAM and SFRs
// - Indirect: R0/R1 give 8-bit, pointer 16-bit
// - Register mode picks R0-R7 in bank
// - Indexed code read: pointer or PC plus accumulator
// - Bit mode selects one of 256 bits
// - Implied accumulator; immediates from instruction bytes
// - Register to/from accumulator: 1 byte, 1 cycle
// - Accumulator from direct: 2 bytes, 2 cycles
// - Accumulator from indirect RAM: 1 byte, 2 cycles
// - Immediate to accumulator or register: 2/2
// - Register from direct: 2 bytes, 3 cycles
// - Accumulator or register to direct: 2/2
// - Direct to direct, immediate to direct: 3/3
// - Indirect RAM to direct: 2 bytes, 3 cycles
// - Indirect writes: 1/2, 2/3, 2/2
// - Pointer load with 16-bit constant: 3/3
// - Code reads: pointer 5 cycles, PC 4
// - External reads: 8-bit 4, 16-bit 3 cycles
// - External writes: 8-bit 5, 16-bit 4 cycles
// - Push 2 bytes 3 cycles; pop 2/2
// - Exchange: register 1/2, direct 2/3, indirect 1/3
// - Low-digit exchange with indirect RAM: 1/3
`ifndef CDM_REGS_SVH
`define CDM_REGS_SVH
// Special function register addresses
`define CDM_SFR_ACC 8'hE0
`define CDM_SFR_B 8'hF0
`define CDM_SFR_PSW 8'hD0
`define CDM_SFR_SP 8'h81
`define CDM_SFR_DPL 8'h82
`define CDM_SFR_DPH 8'h83
// Reset values
`define CDM_SP_RST 8'h07
`define CDM_BYTE_RST 8'h00
`define CDM_DATA_POINTER_RST 16'h0000
// Bank select field in the status word
`define CDM_PSW_BANK_HI 4
`define CDM_PSW_BANK_LO 3
// High nibble of the bit-addressable byte area
`define CDM_BIT_AREA 4'h2
// Upper address byte for 8-bit external accesses
`define CDM_XPAGE 8'h00
// One cycle step of the instruction timer
`define CDM_CYC_ONE 3'h1
`endif

// ==== include/cdm_pkg.sv ====
// Types for the data-move decoder and executor
`default_nettype none
package cdm_pkg;
	// Instruction classes of the data-move group
	typedef enum logic [4:0] {
		OP_NONE = 5'b00000, OP_MOV_A_R = 5'b00001, OP_MOV_A_D = 5'b00010,
		OP_MOV_A_I = 5'b00011, OP_MOV_A_K = 5'b00100, OP_MOV_R_A = 5'b00101,
		OP_MOV_R_D = 5'b00110, OP_MOV_R_K = 5'b00111, OP_MOV_D_A = 5'b01000,
		OP_MOV_D_R = 5'b01001, OP_MOV_D_D = 5'b01010, OP_MOV_D_I = 5'b01011,
		OP_MOV_D_K = 5'b01100, OP_MOV_I_A = 5'b01101, OP_MOV_I_D = 5'b01110,
		OP_MOV_I_K = 5'b01111, OP_MOV_DP_K = 5'b10000, OP_MOVC_DP = 5'b10001,
		OP_MOVC_PC = 5'b10010, OP_MOVX_RI = 5'b10011, OP_MOVX_RDP = 5'b10100,
		OP_MOVX_WI = 5'b10101, OP_MOVX_WDP = 5'b10110, OP_PUSH = 5'b10111,
		OP_POP = 5'b11000, OP_XCH_R = 5'b11001, OP_XCH_D = 5'b11010,
		OP_XCH_I = 5'b11011, OP_XCHD = 5'b11100
	} cdm_op_e;
	// Addressing mode of the source operand
	typedef enum logic [2:0] {
		MD_NONE = 3'b000, MD_DIR = 3'b001, MD_IND8 = 3'b010, MD_IND16 = 3'b011,
		MD_REG = 3'b100, MD_IMPL = 3'b101, MD_IMM = 3'b110, MD_INDEX = 3'b111
	} cdm_mode_e;
	// Instruction bytes as presented by fetch
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] op1;
		logic [7:0] op2;
	} cdm_instr_s;
	// Decoded class, mode, length and time
	typedef struct packed {
		cdm_op_e   op;
		cdm_mode_e mode;
		logic [1:0] bytes;
		logic [2:0] cycles;
	} cdm_info_s;
endpackage : cdm_pkg
`default_nettype wire

// ==== verilog/cdm_bit_locate.sv ====
// Bit operand to byte address and bit position
`default_nettype none
`include "cdm_regs.svh"
module cdm_bit_locate (
	// Bit operand
	input  wire logic [7:0] i_bit_addr,
	// Holding byte and position
	output logic [7:0]      o_byte_addr,
	output logic [2:0]      o_bit_index
);
	// Low half in bit area, high half in SFRs on 8-byte bounds
	assign o_byte_addr = i_bit_addr[7] ? {i_bit_addr[7:3], 3'h0}
		: {`CDM_BIT_AREA, i_bit_addr[6:3]};
	assign o_bit_index = i_bit_addr[2:0];
endmodule : cdm_bit_locate
`default_nettype wire

// ==== verilog/cdm_cycle_timer.sv ====
// Down counter holding an instruction for its cycle count
`default_nettype none
`include "cdm_regs.svh"
module cdm_cycle_timer (
	// Clock, reset, enable
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	input  wire logic       i_ce,
	// Start of an instruction
	input  wire logic       i_load,
	input  wire logic [2:0] i_cycles,
	// Timer state
	output logic            o_idle,
	output logic            o_last
);
	logic [2:0] remain_reg;

	// Reload on start, count down to idle
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			remain_reg <= 3'h0;
		end else if (i_ce) begin
			if (i_load) begin
				remain_reg <= i_cycles - `CDM_CYC_ONE;
			end else if (remain_reg != 3'h0) begin
				remain_reg <= remain_reg - `CDM_CYC_ONE;
			end
		end
	end

	assign o_idle = (remain_reg == 3'h0);
	assign o_last = (remain_reg == `CDM_CYC_ONE);
endmodule : cdm_cycle_timer
`default_nettype wire

// ==== sim/cdm_mem_model.sv ====
// Program and external data memory model for the data-move bench
`default_nettype none
module cdm_mem_model (
	// Clock
	input  wire logic        i_sys_clk,
	// Program memory
	input  wire logic        i_code_rd,
	input  wire logic [15:0] i_code_addr,
	output logic      [7:0]  o_code_rdata,
	// External data memory
	input  wire logic        i_xmem_rd,
	input  wire logic        i_xmem_wr,
	input  wire logic [15:0] i_xmem_addr,
	input  wire logic [7:0]  i_xmem_wdata,
	output logic      [7:0]  o_xmem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] xmem [0:65535];
	initial o_code_rdata = 8'h00;
	initial o_xmem_rdata = 8'h00;
	// Answer one cycle after a strobe; otherwise the stale byte toggles
	always @(posedge i_sys_clk) begin
		o_code_rdata <= i_code_rd ? (i_code_addr[7:0] ^ i_code_addr[15:8]) : ~o_code_rdata;
		o_xmem_rdata <= i_xmem_rd ? xmem[i_xmem_addr] : ~o_xmem_rdata;
		if (i_xmem_wr) begin
			xmem[i_xmem_addr] <= i_xmem_wdata;
		end
	end
endmodule : cdm_mem_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the data-move decoder
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, srst = 1'b1, vld = 1'b0, ce = 1'b1, crd, xrd, xwr, bitv, rdy, done;
	logic [7:0] bit_addr = 8'h00, crdat, xrdat, xwd, acc, sp, psw;
	logic [15:0] caddr, xaddr, data_pointer;
	cdm_pkg::cdm_instr_s instr = '0;
	cdm_pkg::cdm_info_s info;
	int bad_count = 0, samples_checked = 0, cyc = 0;
	// Opcode, bytes, cycles of one instruction from every data-move class
	logic [15:0] tbl [28] = '{16'hE811, 16'hE522, 16'hE612, 16'h7422, 16'hF811, 16'hA823,
		16'h7822, 16'hF522, 16'h8822, 16'h8533, 16'h8623, 16'h7533, 16'hF612, 16'hA623,
		16'h7622, 16'h9033, 16'h9315, 16'h8314, 16'hE214, 16'hE013, 16'hF215, 16'hF014,
		16'hC023, 16'hD022, 16'hC812, 16'hC523, 16'hC613, 16'hD613};
	always #20 clk = ~clk;
	cdm_data_move cdm_data_move_inst (.i_sys_clk(clk), .i_srst(srst), .i_ce(ce),
		.i_instr_valid(vld), .i_instr(instr), .i_pc(16'h0100), .o_instr_ready(rdy),
		.o_done(done), .o_info(info), .o_code_rd(crd), .o_code_addr(caddr),
		.i_code_rdata(crdat), .o_xmem_rd(xrd), .o_xmem_wr(xwr), .o_xmem_addr(xaddr),
		.o_xmem_wdata(xwd), .i_xmem_rdata(xrdat), .i_bit_addr(bit_addr),
		.o_bit_value(bitv), .o_acc(acc), .o_sp(sp), .o_psw(psw), .o_data_pointer(data_pointer));
	cdm_mem_model cdm_mem_model_inst (.i_sys_clk(clk), .i_code_rd(crd), .i_code_addr(caddr),
		.o_code_rdata(crdat), .i_xmem_rd(xrd), .i_xmem_wr(xwr), .i_xmem_addr(xaddr),
		.i_xmem_wdata(xwd), .o_xmem_rdata(xrdat));
	// Compare one value
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Closing verdict
	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// Offer one instruction and count cycles up to done
	task automatic run(input logic [7:0] op, a, b, output int n);
		@(negedge clk);
		vld = 1'b1;
		instr = '{op, a, b};
		n = 1;
		#1;
		while (done !== 1'b1 && n < 9) begin
			@(negedge clk);
			vld = 1'b0;
			n++;
			#1;
		end
		@(negedge clk);
		vld = 1'b0;
	endtask : run
	// Reset state of the core
	task automatic t_reset;
		chk("sp", 16'h0007, {8'h00, sp});
		chk("acc", 16'h0000, {8'h00, acc});
		chk("data_pointer", 16'h0000, data_pointer);
		chk("psw", 16'h0000, {8'h00, psw});
		chk("ready", 16'h0001, {15'h0000, rdy});
	endtask : t_reset
	// Length and timing of every instruction class
	task automatic t_timing;
		int n;
		foreach (tbl[i]) begin
			run(tbl[i][15:8], 8'h30, 8'h31, n);
			chk("cycles", {12'h000, tbl[i][3:0]}, n[15:0]);
			chk("bytes", {12'h000, tbl[i][7:4]}, {14'h0000, info.bytes});
		end
	endtask : t_timing
	// Data through pointer, external memory, code memory and stack
	task automatic t_data;
		int n;
		run(8'h74, 8'h5A, 8'h00, n);
		bit_addr = 8'hE1;
		@(negedge clk);
		chk("bit", 16'h0001, {15'h0000, bitv});
		run(8'h90, 8'h12, 8'h34, n);
		chk("data_pointer", 16'h1234, data_pointer);
		run(8'hF0, 8'h00, 8'h00, n);
		chk("xaddr", 16'h1234, xaddr);
		chk("xwdata", 16'h005A, {8'h00, xwd});
		run(8'h74, 8'h00, 8'h00, n);
		run(8'hE0, 8'h00, 8'h00, n);
		chk("acc xrd", 16'h005A, {8'h00, acc});
		run(8'h93, 8'h00, 8'h00, n);
		chk("acc movc dp", 16'h009C, {8'h00, acc});
		run(8'h83, 8'h00, 8'h00, n);
		chk("acc movc pc", 16'h009D, {8'h00, acc});
		run(8'hC0, 8'hE0, 8'h00, n);
		chk("sp push", 16'h0008, {8'h00, sp});
		run(8'hD0, 8'h82, 8'h00, n);
		chk("sp pop", 16'h0007, {8'h00, sp});
		chk("data_pointer pop", 16'h129D, data_pointer);
		// Enable low: an offered load must not be taken
		@(negedge clk);
		ce = 1'b0;
		vld = 1'b1;
		instr = '{8'h74, 8'h33, 8'h00};
		repeat (3) @(negedge clk);
		chk("acc frozen", 16'h009D, {8'h00, acc});
		vld = 1'b0;
		ce = 1'b1;
		@(negedge clk);
		chk("acc after enable", 16'h009D, {8'h00, acc});
	endtask : t_data
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		#1;
		t_reset();
		t_timing();
		t_data();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
